// ==== rtl/sftc_fifo.sv ====
// Small valid/ready FIFO between receiver and trap logic
module sftc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             mclk_in,
  input  wire logic             nrst_in,
  // Fill side
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  // Drain side
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_ready_in && (count != '0);
  assign next_count    = count + (AW+1)'(push) - (AW+1)'(pop);
  assign out_valid_out = (count != '0);
  assign out_data_out  = mem[rd_ptr];

  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      in_ready_out <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count        <= next_count;
      in_ready_out <= (next_count != DEPTH[AW:0]);
    end
  end
endmodule : sftc_fifo

// ==== rtl/sftc_pkg.sv ====
// Shared constants and types for the serial flow control and trap capture block
package sftc_pkg;

  // ----------------------------------------------------------------
  // Control characters per language
  // ----------------------------------------------------------------
  localparam logic [7:0] ASCII_RESUME   = 8'h11;
  localparam logic [7:0] ASCII_PAUSE    = 8'h13;
  localparam logic [7:0] ASCII_ACK      = 8'h06;
  localparam logic [7:0] EBCDIC_RESUME  = 8'h11;
  localparam logic [7:0] EBCDIC_PAUSE   = 8'h13;
  localparam logic [7:0] EBCDIC_ACK     = 8'h2E;
  localparam logic [7:0] BAUDOT_CODE    = 8'h00;
  localparam logic [7:0] TRANS_RESUME   = 8'h0A;
  localparam logic [7:0] TRANS_PAUSE    = 8'h2E;
  localparam logic [7:0] TRANS_ACK      = 8'h2D;
  localparam logic [7:0] IPARS_RESUME   = 8'h20;
  localparam logic [7:0] IPARS_PAUSE    = 8'h12;
  localparam logic [7:0] IPARS_ACK      = 8'h3F;

  // ----------------------------------------------------------------
  // Trap buffer geometry
  // ----------------------------------------------------------------
  localparam int          TRAP_DEPTH    = 4096;
  localparam int          TRAP_AW       = 12;
  localparam logic [12:0] TRAP_FULL     = 13'h1000;
  localparam logic [12:0] CENTER_PRE    = 13'h07FF;
  localparam logic [12:0] CENTER_POST   = 13'h0800;
  localparam int          MSG_COUNT     = 16;
  localparam int          MSG_LEN       = 8;
  localparam int          FIFO_DEPTH    = 4;

  // ----------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SFTC_LANG_HEX, SFTC_LANG_ASCII, SFTC_LANG_EBCDIC,
    SFTC_LANG_BAUDOT, SFTC_LANG_TRANS, SFTC_LANG_IPARS
  } sftc_lang_t;

  typedef enum logic [1:0] {
    SFTC_FLOW_NONE, SFTC_FLOW_HW, SFTC_FLOW_SW, SFTC_FLOW_BOTH
  } sftc_flow_t;

  typedef enum logic [1:0] {
    SFTC_COLL_BEFORE, SFTC_COLL_AFTER, SFTC_COLL_CENTER
  } sftc_coll_t;

  typedef enum logic [1:0] {
    SFTC_TRIG_START, SFTC_TRIG_LINE, SFTC_TRIG_MSG, SFTC_TRIG_ADDR
  } sftc_trig_t;

  // Setup bundle handed in by the front panel logic
  typedef struct packed {
    logic       modem_role;
    sftc_lang_t lang;
    logic       resume_ack;
    logic       user_chars;
    logic [7:0] user_resume;
    logic [7:0] user_pause;
    sftc_flow_t flow;
    logic [1:0] line_in_sel;
    logic [1:0] line_out_sel;
    sftc_coll_t coll;
    sftc_trig_t trig;
    logic [3:0] msg_sel;
    logic [7:0] frame_addr;
  } sftc_cfg_t;

  // Handshake pins; terminal role drives out[3:0] = rts,dtr,aux11,aux19
  // modem role drives out[2:0] = cts,dsr,dcd
  typedef struct packed {
    logic [3:0] hs;
  } sftc_hs_t;

endpackage : sftc_pkg

// ==== rtl/sftc_top.sv ====
// Flow control and trigger capture logic of the serial test port
// ----------------------------------------------------------------
// What this block does
// - Resume sending on resume character after pause
// - Flow key sends resume and pause alternately
// - Codes follow language; ASCII 11H 13H 06H
// - Hardware flow: send only while input high
// - Input line change triggers capture
// - Any of four input lines selectable in both roles
// - Drive role outputs high, toggle selected one
// - Pre-trigger keeps 4096; not with start trigger
// - Post-trigger stores next 4096 then stops
// - Centered: 2047 before, 2048 after
// - Centered short history filled after trigger
// - Flow none: no signalling, no reaction
// - Flow both: generate and obey both kinds
// - Flow key toggles receive flow state
// - Flow characters go on own data line
// - Pause character silences until resume
// - Terminal role: send TD, receive RD
// - Modem role: send RD, receive TD
// - Message match trigger at last character
// - Address trigger compares SDLC address field
// ----------------------------------------------------------------
module sftc_top #(
  parameter int DEPTH = sftc_pkg::TRAP_DEPTH
) (
  // Clock and reset
  input  wire logic                mclk_in,
  input  wire logic                nrst_in,
  // Setup and controls
  input  wire sftc_pkg::sftc_cfg_t cfg_in,
  input  wire logic                test_start_in,
  input  wire logic                flow_key_in,
  input  wire logic [7:0]          msg_wr_data_in,
  input  wire logic [6:0]          msg_wr_addr_in,
  input  wire logic                msg_wr_in,
  // Character streams from the serialisers
  input  wire logic                rx_valid_in,
  input  wire logic [7:0]          rx_data_in,
  input  wire logic                rx_frame_start_in,
  output logic                     rx_ready_out,
  input  wire logic                tx_req_in,
  input  wire logic [7:0]          tx_data_in,
  output logic                     tx_ack_out,
  input  wire logic                tx_busy_in,
  // Handshake pins
  input  wire sftc_pkg::sftc_hs_t  hs_pin_in,
  output sftc_pkg::sftc_hs_t       hs_pin_out,
  // Transmit character to the serialiser with line select
  output logic                     ser_valid_out,
  output logic [7:0]               ser_data_out,
  output logic                     ser_on_rd_out,
  // Trap status and readout
  output logic                     triggered_out,
  output logic                     capture_done_out,
  output logic                     tx_paused_out,
  input  wire logic [11:0]         trap_rd_addr_in,
  output logic [7:0]               trap_rd_data_out,
  output logic [11:0]              trig_pos_out
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] hs_meta;
  logic [3:0] hs_sync;
  logic       in_line;
  logic       in_line_q;
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      hs_meta <= 4'h0;
      hs_sync <= 4'h0;
    end else begin
      hs_meta <= hs_pin_in.hs;
      hs_sync <= hs_meta;
    end
  end
  // Either role can select any of the four handshake inputs with line_in_sel
  assign in_line = hs_sync[cfg_in.line_in_sel];

  // ----------------------------------------------------------------
  // Control characters
  // ----------------------------------------------------------------
  logic [7:0] resume_chr;
  logic [7:0] pause_chr;
  always_comb begin
    unique case (cfg_in.lang)
      sftc_pkg::SFTC_LANG_EBCDIC: begin
        resume_chr = cfg_in.resume_ack ? sftc_pkg::EBCDIC_ACK : sftc_pkg::EBCDIC_RESUME;
        pause_chr  = sftc_pkg::EBCDIC_PAUSE;
      end
      sftc_pkg::SFTC_LANG_BAUDOT: begin
        resume_chr = sftc_pkg::BAUDOT_CODE;
        pause_chr  = sftc_pkg::BAUDOT_CODE;
      end
      sftc_pkg::SFTC_LANG_TRANS: begin
        resume_chr = cfg_in.resume_ack ? sftc_pkg::TRANS_ACK : sftc_pkg::TRANS_RESUME;
        pause_chr  = sftc_pkg::TRANS_PAUSE;
      end
      sftc_pkg::SFTC_LANG_IPARS: begin
        resume_chr = cfg_in.resume_ack ? sftc_pkg::IPARS_ACK : sftc_pkg::IPARS_RESUME;
        pause_chr  = sftc_pkg::IPARS_PAUSE;
      end
      default: begin
        resume_chr = cfg_in.resume_ack ? sftc_pkg::ASCII_ACK : sftc_pkg::ASCII_RESUME;
        pause_chr  = sftc_pkg::ASCII_PAUSE;
      end
    endcase
    if (cfg_in.user_chars) begin
      resume_chr = cfg_in.user_resume;
      pause_chr  = cfg_in.user_pause;
    end
  end

  logic hw_on;
  logic sw_on;
  assign hw_on = (cfg_in.flow == sftc_pkg::SFTC_FLOW_HW) ||
                 (cfg_in.flow == sftc_pkg::SFTC_FLOW_BOTH);
  assign sw_on = (cfg_in.flow == sftc_pkg::SFTC_FLOW_SW) ||
                 (cfg_in.flow == sftc_pkg::SFTC_FLOW_BOTH);

  // ----------------------------------------------------------------
  // Receive FIFO
  // ----------------------------------------------------------------
  logic       f_valid;
  logic [7:0] f_data;
  logic       f_ready;
  sftc_fifo #(
    .WIDTH (8),
    .DEPTH (sftc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .mclk_in       (mclk_in),
    .nrst_in       (nrst_in),
    .in_valid_in   (rx_valid_in),
    .in_data_in    (rx_data_in),
    .in_ready_out  (rx_ready_out),
    .out_valid_out (f_valid),
    .out_data_out  (f_data),
    .out_ready_in  (f_ready)
  );
  // Trap writes one character per clock, so the drain is always ready and never stalls
  assign f_ready = 1'b1;
  logic rx_take;
  assign rx_take = f_valid;

  // ----------------------------------------------------------------
  // Received pause / resume for our own transmitter
  // ----------------------------------------------------------------
  logic sw_paused;
  always_ff @(posedge mclk_in) begin
    if (!nrst_in || !sw_on) begin
      sw_paused <= 1'b0;
    end else if (rx_take && f_data == pause_chr) begin
      sw_paused <= 1'b1;
    end else if (rx_take && f_data == resume_chr) begin
      sw_paused <= 1'b0;
    end
  end

  logic tx_allowed;
  assign tx_allowed = !(sw_on && sw_paused) && !(hw_on && !in_line);

  // ----------------------------------------------------------------
  // Flow key: receive-side flow state and character sending
  // ----------------------------------------------------------------
  logic key_q;
  logic key_edge;
  logic rx_flow_off;
  logic chr_pending;
  logic [7:0] chr_val;
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      key_q <= 1'b0;
    end else begin
      key_q <= flow_key_in;
    end
  end
  assign key_edge = flow_key_in && !key_q;

  always_ff @(posedge mclk_in) begin
    if (!nrst_in || cfg_in.flow == sftc_pkg::SFTC_FLOW_NONE) begin
      rx_flow_off <= 1'b0;
    end else if (key_edge) begin
      rx_flow_off <= !rx_flow_off;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      chr_pending <= 1'b0;
      chr_val     <= 8'h00;
    end else if (key_edge && sw_on) begin
      chr_pending <= 1'b1;
      chr_val     <= rx_flow_off ? resume_chr : pause_chr;
    end else if (chr_pending && !tx_busy_in && !ser_valid_out) begin
      chr_pending <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transmit path and line routing
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      ser_valid_out <= 1'b0;
      ser_data_out  <= 8'h00;
      tx_ack_out    <= 1'b0;
    end else begin
      ser_valid_out <= 1'b0;
      tx_ack_out    <= 1'b0;
      if (!tx_busy_in && !ser_valid_out) begin
        if (chr_pending) begin
          ser_valid_out <= 1'b1;
          ser_data_out  <= chr_val;
        end else if (tx_req_in && tx_allowed) begin
          ser_valid_out <= 1'b1;
          ser_data_out  <= tx_data_in;
          tx_ack_out    <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      ser_on_rd_out <= 1'b0;
      tx_paused_out <= 1'b0;
    end else begin
      ser_on_rd_out <= cfg_in.modem_role;
      tx_paused_out <= !tx_allowed;
    end
  end

  // ----------------------------------------------------------------
  // Handshake outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      hs_pin_out.hs <= 4'h0;
    end else begin
      // Terminal role drives four lines, modem role three
      hs_pin_out.hs <= cfg_in.modem_role ? 4'h7 : 4'hF;
      if (hw_on && rx_flow_off) begin
        hs_pin_out.hs[cfg_in.line_out_sel] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Trigger sources
  // ----------------------------------------------------------------
  logic [7:0] msgs [sftc_pkg::MSG_COUNT * sftc_pkg::MSG_LEN];
  logic [2:0] match_idx;
  logic       msg_hit;
  logic       addr_hit;
  logic       addr_wait;
  logic       line_hit;
  logic [7:0] msg_chr;
  always_ff @(posedge mclk_in) begin
    if (msg_wr_in) begin
      msgs[msg_wr_addr_in] <= msg_wr_data_in;
    end
  end
  assign msg_chr = msgs[{cfg_in.msg_sel, match_idx}];

  always_ff @(posedge mclk_in) begin
    if (!nrst_in || test_start_in) begin
      match_idx <= 3'h0;
    end else if (rx_take) begin
      if (f_data == msg_chr) begin
        match_idx <= match_idx + 3'h1;
      end else begin
        match_idx <= 3'h0;
      end
    end
  end
  // Trigger on the last character of the selected message
  assign msg_hit = rx_take && f_data == msg_chr && match_idx == 3'h7;

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      addr_wait <= 1'b0;
    end else if (rx_frame_start_in) begin
      addr_wait <= 1'b1;
    end else if (rx_take) begin
      addr_wait <= 1'b0;
    end
  end
  assign addr_hit = addr_wait && rx_take && f_data == cfg_in.frame_addr;
  assign line_hit = in_line != in_line_q;

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      in_line_q <= 1'b0;
    end else begin
      in_line_q <= in_line;
    end
  end

  logic trig_now;
  always_comb begin
    unique case (cfg_in.trig)
      sftc_pkg::SFTC_TRIG_START: trig_now = test_start_in;
      sftc_pkg::SFTC_TRIG_LINE:  trig_now = line_hit;
      sftc_pkg::SFTC_TRIG_MSG:   trig_now = msg_hit;
      sftc_pkg::SFTC_TRIG_ADDR:  trig_now = addr_hit;
    endcase
  end

  // ----------------------------------------------------------------
  // Trap buffer control
  // ----------------------------------------------------------------
  logic [11:0] wr_ptr;
  logic [12:0] pre_cnt;
  logic [12:0] post_cnt;
  logic [12:0] post_quota;
  logic        armed;
  logic        running;
  logic        wr_en;

  // Before-trigger with start trigger is refused: capture stops at once
  always_comb begin
    unique case (cfg_in.coll)
      sftc_pkg::SFTC_COLL_BEFORE: post_quota = 13'h0000;
      sftc_pkg::SFTC_COLL_CENTER: begin
        if (pre_cnt < sftc_pkg::CENTER_PRE) begin
          post_quota = sftc_pkg::TRAP_FULL - pre_cnt;
        end else begin
          post_quota = sftc_pkg::CENTER_POST;
        end
      end
      default: post_quota = sftc_pkg::TRAP_FULL;
    endcase
  end

  assign wr_en = running && rx_take && (!triggered_out || post_cnt < post_quota);

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      running          <= 1'b0;
      armed            <= 1'b0;
      triggered_out    <= 1'b0;
      capture_done_out <= 1'b0;
      wr_ptr           <= 12'h000;
      pre_cnt          <= 13'h0000;
      post_cnt         <= 13'h0000;
      trig_pos_out     <= 12'h000;
    end else if (test_start_in) begin
      running          <= 1'b1;
      armed            <= 1'b1;
      triggered_out    <= 1'b0;
      capture_done_out <= 1'b0;
      wr_ptr           <= 12'h000;
      pre_cnt          <= 13'h0000;
      post_cnt         <= 13'h0000;
      if (cfg_in.trig == sftc_pkg::SFTC_TRIG_START) begin
        armed         <= 1'b0;
        triggered_out <= 1'b1;
      end
    end else begin
      if (wr_en) begin
        wr_ptr <= wr_ptr + 12'h001;
        if (triggered_out) begin
          post_cnt <= post_cnt + 13'h0001;
        end else if (pre_cnt != sftc_pkg::TRAP_FULL) begin
          pre_cnt <= pre_cnt + 13'h0001;
        end
      end
      if (armed && trig_now) begin
        armed         <= 1'b0;
        triggered_out <= 1'b1;
        trig_pos_out  <= wr_ptr;
        // Centered mode drops history older than the 2047 before
      end
      if (running && triggered_out && post_cnt >= post_quota) begin
        running          <= 1'b0;
        capture_done_out <= 1'b1;
      end
    end
  end

  logic [7:0] trap_mem [DEPTH];
  always_ff @(posedge mclk_in) begin
    if (wr_en) begin
      trap_mem[wr_ptr] <= f_data;
    end
  end
  always_ff @(posedge mclk_in) begin
    trap_rd_data_out <= trap_mem[trap_rd_addr_in];
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_pause_stops_tx: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (sw_on && sw_paused && !chr_pending) |=> !tx_ack_out)
    else $error("data sent while paused");
  a_hw_line_low: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (hw_on && !in_line) |=> !tx_ack_out)
    else $error("data sent with input line low");
  a_none_no_pause: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (cfg_in.flow == sftc_pkg::SFTC_FLOW_NONE) |=> !tx_paused_out)
    else $error("pause with flow none");
  a_key_toggles: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (key_edge && cfg_in.flow != sftc_pkg::SFTC_FLOW_NONE) |=> rx_flow_off != $past(rx_flow_off))
    else $error("flow state did not toggle");
  a_role_route: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    $stable(cfg_in.modem_role) |=> ser_on_rd_out == $past(cfg_in.modem_role))
    else $error("wrong transmit line");
  a_post_bound: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    post_cnt <= sftc_pkg::TRAP_FULL)
    else $error("post count overrun");
  a_done_stops: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (capture_done_out && !test_start_in) |-> !wr_en)
    else $error("write after capture done");
  a_resume_clears: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (sw_on && rx_take && f_data == resume_chr && f_data != pause_chr) |=> !sw_paused)
    else $error("resume ignored");
  sequence s_chr_slot;
    chr_pending && !tx_busy_in && !ser_valid_out;
  endsequence
  a_flow_chr_first: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    s_chr_slot |=> ser_valid_out && !tx_ack_out && ser_data_out == $past(chr_val))
    else $error("flow character not sent");
endmodule : sftc_top

// ==== tb/sftc_far_model.sv ====
// Far-end serial device model: sends characters, drives handshake lines, logs what arrives
module sftc_far_model (
  // Clock
  input  wire logic               mclk_in,
  // Characters towards the block
  output logic                    rx_valid_out,
  output logic [7:0]              rx_data_out,
  input  wire logic               rx_ready_in,
  // Characters from the block
  input  wire logic               ser_valid_in,
  input  wire logic [7:0]         ser_data_in,
  output logic                    tx_busy_out,
  // Handshake lines
  output sftc_pkg::sftc_hs_t      hs_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] last_ch;
  int         n_ch;

  initial begin
    rx_valid_out = 1'b0;
    rx_data_out  = 8'h00;
    hs_out       = '{hs: 4'hF};
    last_ch      = 8'h00;
    n_ch         = 0;
  end

  // Busy for one cycle after each character
  always @(posedge mclk_in) begin
    tx_busy_out <= (ser_valid_in === 1'b1);
    if (ser_valid_in === 1'b1) begin
      last_ch <= ser_data_in;
      n_ch    <= n_ch + 1;
    end
  end

  task automatic send_char(input logic [7:0] d);
    @(posedge mclk_in);
    rx_valid_out <= 1'b1;
    rx_data_out  <= d;
    do @(negedge mclk_in); while (rx_ready_in !== 1'b1);
    @(posedge mclk_in);
    rx_valid_out <= 1'b0;
    rx_data_out  <= ~d;
  endtask : send_char

  task automatic set_line(input int b, input logic v);
    @(posedge mclk_in);
    hs_out.hs[b] <= v;
  endtask : set_line
endmodule : sftc_far_model

// ==== tb/sftc_top_tb.sv ====
// Self-checking testbench of the flow control and trap capture block
module sftc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                mclk_in = 1'b0;
  logic                nrst_in = 1'b0;
  sftc_pkg::sftc_cfg_t cfg;
  logic                test_start = 1'b0;
  logic                flow_key   = 1'b0;
  logic                tx_req     = 1'b0;
  logic [7:0]          tx_data    = 8'h00;
  logic                rx_valid, rx_ready, tx_ack, tx_busy;
  logic                msg_wr = 1'b0, rx_frame = 1'b0;
  logic [6:0]          msg_addr = 7'h00;
  logic [7:0]          msg_data = 8'h00;
  logic [11:0]         trap_rd = 12'h000, trig_pos;
  logic [7:0]          rx_data, ser_data_out, rd_data;
  sftc_pkg::sftc_hs_t  hs_in, hs_pin_out;
  logic                ser_valid, ser_on_rd_out, triggered_out, capture_done_out, tx_paused_out;
  int                  error_cnt = 0;
  int                  checks    = 0;

  always #12.5 mclk_in = ~mclk_in;

  sftc_far_model far (.mclk_in(mclk_in), .rx_valid_out(rx_valid), .rx_data_out(rx_data),
    .rx_ready_in(rx_ready), .ser_valid_in(ser_valid), .ser_data_in(ser_data_out),
    .tx_busy_out(tx_busy), .hs_out(hs_in));

  sftc_top dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .cfg_in(cfg), .test_start_in(test_start),
    .flow_key_in(flow_key), .msg_wr_data_in(msg_data), .msg_wr_addr_in(msg_addr),
    .msg_wr_in(msg_wr), .rx_valid_in(rx_valid), .rx_data_in(rx_data),
    .rx_frame_start_in(rx_frame),
    .rx_ready_out(rx_ready), .tx_req_in(tx_req), .tx_data_in(tx_data), .tx_ack_out(tx_ack),
    .tx_busy_in(tx_busy), .hs_pin_in(hs_in), .hs_pin_out(hs_pin_out), .ser_valid_out(ser_valid),
    .ser_data_out(ser_data_out), .ser_on_rd_out(ser_on_rd_out), .triggered_out(triggered_out),
    .capture_done_out(capture_done_out), .tx_paused_out(tx_paused_out),
    .trap_rd_addr_in(trap_rd), .trap_rd_data_out(rd_data), .trig_pos_out(trig_pos));

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task automatic chk_bit(input logic g, input logic e, input string m);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk_bit

  task automatic chk_val(input logic [11:0] g, input logic [11:0] e, input string m);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask : chk_val

  task automatic idle(input int n);
    repeat (n) @(negedge mclk_in);
  endtask : idle

  // Request held until acknowledged; a refused request is withdrawn after the wait
  task automatic tx_try(input logic [7:0] d, input logic ok);
    logic got;
    got = 1'b0;
    @(posedge mclk_in);
    tx_req  <= 1'b1;
    tx_data <= d;
    for (int i = 0; i < 12 && !got; i++) begin
      @(negedge mclk_in);
      got = (tx_ack === 1'b1);
    end
    chk_bit(got, ok, "tx accept");
    if (got) chk_val(ser_data_out, d, "tx data");
    @(posedge mclk_in);
    tx_req <= 1'b0;
  endtask : tx_try

  task automatic press;
    @(posedge mclk_in);
    flow_key <= 1'b1;
    repeat (4) @(posedge mclk_in);
    flow_key <= 1'b0;
    idle(8);
  endtask : press

  task automatic send_n(input int n);
    for (int i = 0; i < n; i++) far.send_char(i[7:0]);
    idle(10);
  endtask : send_n

  task automatic start_trap(input sftc_pkg::sftc_trig_t t, input sftc_pkg::sftc_coll_t c);
    @(posedge mclk_in);
    cfg.trig   <= t;
    cfg.coll   <= c;
    test_start <= 1'b1;
    @(posedge mclk_in);
    test_start <= 1'b0;
    idle(4);
  endtask : start_trap

  task automatic end_sim;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    #2000000;
    error_cnt++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    cfg      = '0;
    cfg.lang = sftc_pkg::SFTC_LANG_ASCII;
    cfg.flow = sftc_pkg::SFTC_FLOW_SW;
    cfg.frame_addr = 8'h5A;
    repeat (10) @(posedge mclk_in);
    nrst_in <= 1'b1;
    idle(3);
    chk_val({4'h0, hs_pin_out.hs}, 8'h0F, "terminal outputs");
    tx_try(8'h41, 1'b1);
    chk_bit(ser_on_rd_out, 1'b0, "terminal line");
    $display("test basic send done");
    far.send_char(8'h13);
    idle(6);
    chk_bit(tx_paused_out, 1'b1, "paused");
    tx_try(8'h42, 1'b0);
    far.send_char(8'h11);
    idle(6);
    tx_try(8'h42, 1'b1);
    $display("test character flow done");
    press();
    chk_val(far.last_ch, 8'h13, "key pause char");
    chk_bit(ser_on_rd_out, 1'b0, "flow char line");
    press();
    chk_val(far.last_ch, 8'h11, "key resume char");
    $display("test flow key done");
    @(posedge mclk_in);
    cfg.flow <= sftc_pkg::SFTC_FLOW_HW;
    far.set_line(0, 1'b0);
    idle(6);
    tx_try(8'h43, 1'b0);
    far.set_line(0, 1'b1);
    idle(6);
    tx_try(8'h43, 1'b1);
    press();
    chk_val({4'h0, hs_pin_out.hs}, 8'h0E, "toggled output");
    $display("test line flow done");
    @(posedge mclk_in);
    cfg.flow <= sftc_pkg::SFTC_FLOW_BOTH;
    press();
    far.send_char(8'h13);
    idle(6);
    tx_try(8'h44, 1'b0);
    far.send_char(8'h11);
    far.set_line(0, 1'b0);
    idle(6);
    tx_try(8'h44, 1'b0);
    far.set_line(0, 1'b1);
    idle(6);
    tx_try(8'h44, 1'b1);
    $display("test both flow done");
    @(posedge mclk_in);
    cfg.modem_role <= 1'b1;
    cfg.flow       <= sftc_pkg::SFTC_FLOW_NONE;
    idle(6);
    tx_try(8'h45, 1'b1);
    chk_bit(ser_on_rd_out, 1'b1, "modem line");
    $display("test modem role done");
    @(posedge mclk_in);
    cfg.modem_role <= 1'b0;
    start_trap(sftc_pkg::SFTC_TRIG_START, sftc_pkg::SFTC_COLL_AFTER);
    chk_bit(triggered_out, 1'b1, "start trigger");
    send_n(4095);
    chk_bit(capture_done_out, 1'b0, "after early");
    send_n(1);
    chk_bit(capture_done_out, 1'b1, "after full");
    chk_bit(tx_paused_out, 1'b0, "none ignores pause");
    tx_try(8'h46, 1'b1);
    $display("test post capture done");
    start_trap(sftc_pkg::SFTC_TRIG_LINE, sftc_pkg::SFTC_COLL_CENTER);
    send_n(100);
    chk_bit(triggered_out, 1'b0, "no trigger yet");
    far.set_line(0, 1'b0);
    idle(6);
    chk_bit(triggered_out, 1'b1, "line trigger");
    send_n(3995);
    chk_bit(capture_done_out, 1'b0, "center early");
    send_n(1);
    chk_bit(capture_done_out, 1'b1, "center full");
    $display("test centered capture done");
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk_in);
      msg_wr   <= 1'b1;
      msg_addr <= i[6:0];
      msg_data <= 8'hA0 + i[7:0];
    end
    @(posedge mclk_in);
    msg_wr <= 1'b0;
    start_trap(sftc_pkg::SFTC_TRIG_MSG, sftc_pkg::SFTC_COLL_AFTER);
    for (int i = 0; i < 7; i++) far.send_char(8'hA0 + i[7:0]);
    idle(6);
    chk_bit(triggered_out, 1'b0, "partial message");
    far.send_char(8'hA7);
    idle(6);
    chk_val(trig_pos, 12'h007, "trigger position");
    @(posedge mclk_in);
    trap_rd <= 12'h007;
    idle(3);
    chk_val(rd_data, 8'hA7, "trapped char");
    $display("test message trap done");
    start_trap(sftc_pkg::SFTC_TRIG_ADDR, sftc_pkg::SFTC_COLL_BEFORE);
    for (int i = 0; i < 2; i++) begin
      @(posedge mclk_in);
      rx_frame <= 1'b1;
      @(posedge mclk_in);
      rx_frame <= 1'b0;
      far.send_char(i[0] ? 8'h5A : 8'h33);
      idle(6);
      chk_bit(triggered_out, i[0], "address match");
    end
    chk_bit(capture_done_out, 1'b1, "before done");
    $display("test address trap done");
    end_sim();
  end
endmodule : sftc_top_tb
